// file: design/usb_irq_enable_frame_index_regs.sv
// Purpose: USB interrupt enables, frame number, endpoint select and endpoint window
// Assumes: Events arrive as one-cycle pulses synchronous to CLOCK_IN
// Notes: APB slave answers with no wait state; unmapped accesses get PSLVERR
`timescale 1ns/1ns

// Overview of operation
// - Eight enable bits for OUT endpoints 8 to 15, bit 0 is endpoint 8.
// - OUT enables reset to 1 for present endpoints, otherwise 0; default all 0.
// - Bus-event enables: SOF bit 3, reset bit 2, resume bit 1, suspend bit 0.
// - After reset, reset and resume enables are 1, SOF and suspend are 0.
// - Bus-event enable bits 7 to 4 ignore writes and read as zero.
// - Read-only low eight bits of last frame number, reset to zero.
// - Read-only frame number bits 10 to 8, reset to zero.
// - Four-bit endpoint select picks which set answers in the shared window.
// - Endpoints 1 to 15 own IN and OUT sets; only the selected one is mapped.
// - Endpoint 0 has one 8-bit control/status register for everything.
// - Flags set on SOF, bus reset, resume while suspended, and suspend.
module usb_irq_enable_frame_index_regs #(
  parameter logic [7:0] OUT_EP_HI_PRESENT = 8'h00
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire usb_regs_pkg::apb_req_t APB_REQ_IN,
  output logic [usb_regs_pkg::DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // USB link events
  input wire usb_regs_pkg::usb_event_t USB_EVENT_IN,
  // Interrupt and window state
  output logic IRQ_OUT,
  output logic [3:0] ENDPOINT_SELECT_OUT,
  output logic SUSPENDED_OUT
);
  import usb_regs_pkg::*;

  logic [7:0] out_ep_hi_irq_enable_reg;
  logic [3:0] bus_event_irq_enable_reg;
  logic [7:0] frame_number_low_reg;
  logic [2:0] frame_number_high_reg;
  logic [3:0] endpoint_select_reg;
  logic [7:0] out_ep_hi_irq_flags_reg;
  logic [3:0] bus_event_irq_flags_reg;
  logic suspended_reg;
  logic [7:0] in_csr_mem [EP_COUNT][EP_WINDOW_REGS];
  logic [7:0] out_csr_mem [EP_COUNT][EP_WINDOW_REGS];

  logic setup_phase;
  logic write_strobe;
  logic [15:0] req_idx;
  logic idx_in_range;
  logic in_window;
  logic [2:0] window_slot;
  logic mapped;
  logic [7:0] read_value;
  logic [7:0] wbyte;
  logic [3:0] bus_event_set;
  logic [7:0] out_ep_hi_set;
  logic irq_next;
  // Register and window decode
  logic hit_out_ep_hi_enable;
  logic hit_bus_event_enable;
  logic hit_frame_low;
  logic hit_frame_high;
  logic hit_endpoint_select;
  logic hit_bus_event_flags;
  logic hit_out_ep_hi_flags;
  logic win_ep_zero;
  logic win_ep_zero_csr;
  logic win_out_slot;
  logic win_in_slot;
  logic wr_window;

  // Register index of a byte address, only valid when aligned and in range
  function automatic logic [15:0] addr_to_idx(input logic [ADDR_W-1:0] a);
    return a[17:2];
  endfunction

  // True for an aligned access to the given register index
  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [15:0] which);
    return (a[1:0] == 2'b00) && (a[ADDR_W-1:18] == '0) && (a[17:2] == which);
  endfunction

  assign setup_phase = APB_REQ_IN.psel && !APB_REQ_IN.penable;
  assign req_idx = addr_to_idx(APB_REQ_IN.paddr);
  assign idx_in_range = (APB_REQ_IN.paddr[1:0] == 2'b00) &&
    (APB_REQ_IN.paddr[ADDR_W-1:18] == '0);
  assign in_window = idx_in_range && (req_idx >= IDX_EP_WINDOW_FIRST) &&
    (req_idx <= IDX_EP_WINDOW_LAST);
  assign window_slot = req_idx[2:0];
  assign wbyte = APB_REQ_IN.pwdata[7:0];
  // Write lands at the access edge where PREADY was already high
  assign write_strobe = APB_REQ_IN.psel && APB_REQ_IN.penable && PREADY_OUT &&
    APB_REQ_IN.pwrite && !PSLVERR_OUT && APB_REQ_IN.pstrb[0];

  // One decode per register, shared by the read mux and the writers
  assign hit_out_ep_hi_enable = is_reg(APB_REQ_IN.paddr, IDX_OUT_EP_HI_IRQ_ENABLE);
  assign hit_bus_event_enable = is_reg(APB_REQ_IN.paddr, IDX_BUS_EVENT_IRQ_ENABLE);
  assign hit_frame_low = is_reg(APB_REQ_IN.paddr, IDX_FRAME_NUMBER_LOW);
  assign hit_frame_high = is_reg(APB_REQ_IN.paddr, IDX_FRAME_NUMBER_HIGH);
  assign hit_endpoint_select = is_reg(APB_REQ_IN.paddr, IDX_ENDPOINT_SELECT);
  assign hit_bus_event_flags = is_reg(APB_REQ_IN.paddr, IDX_BUS_EVENT_IRQ_FLAGS);
  assign hit_out_ep_hi_flags = is_reg(APB_REQ_IN.paddr, IDX_OUT_EP_HI_IRQ_FLAGS);

  // Endpoint 0 owns only its single control/status byte in the window
  assign win_ep_zero = (endpoint_select_reg == 4'h0);
  assign win_ep_zero_csr = win_ep_zero && (window_slot == EP_ZERO_CSR_SLOT);
  assign win_out_slot = !win_ep_zero && window_slot[0];
  assign win_in_slot = !win_ep_zero && !window_slot[0];
  assign wr_window = write_strobe && in_window;

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    read_value = 8'h00;
    if (in_window) begin
      if (win_ep_zero_csr) begin
        read_value = in_csr_mem[0][EP_ZERO_CSR_SLOT];
      end else if (win_out_slot) begin
        read_value = out_csr_mem[endpoint_select_reg][window_slot];
      end else if (win_in_slot) begin
        read_value = in_csr_mem[endpoint_select_reg][window_slot];
      end
    end else if (hit_out_ep_hi_enable) begin
      read_value = out_ep_hi_irq_enable_reg;
    end else if (hit_bus_event_enable) begin
      read_value = {BUS_EVENT_UNUSED, bus_event_irq_enable_reg};
    end else if (hit_frame_low) begin
      read_value = frame_number_low_reg;
    end else if (hit_frame_high) begin
      read_value = {5'h00, frame_number_high_reg};
    end else if (hit_endpoint_select) begin
      read_value = {4'h0, endpoint_select_reg};
    end else if (hit_bus_event_flags) begin
      read_value = {4'h0, bus_event_irq_flags_reg};
    end else if (hit_out_ep_hi_flags) begin
      read_value = out_ep_hi_irq_flags_reg;
    end else begin
      mapped = 1'b0;
    end
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      PREADY_OUT <= 1'b0;
    end else if (setup_phase) begin
      PREADY_OUT <= 1'b1;
    end else begin
      PREADY_OUT <= 1'b0;
    end
  end

  // Unmapped or unaligned access is refused with an error
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      PSLVERR_OUT <= 1'b0;
    end else if (setup_phase) begin
      PSLVERR_OUT <= !mapped;
    end else begin
      PSLVERR_OUT <= 1'b0;
    end
  end

  // Read data only for good reads, zero otherwise
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      PRDATA_OUT <= '0;
    end else if (setup_phase) begin
      PRDATA_OUT <= (mapped && !APB_REQ_IN.pwrite) ? {24'h000000, read_value} : '0;
    end else begin
      PRDATA_OUT <= '0;
    end
  end

  // OUT endpoint 8 to 15 interrupt enables
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      out_ep_hi_irq_enable_reg <= OUT_EP_HI_PRESENT;
    end else if (write_strobe && hit_out_ep_hi_enable) begin
      out_ep_hi_irq_enable_reg <= wbyte;
    end
  end

  // Bus-event interrupt enables, upper nibble not stored
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      bus_event_irq_enable_reg <= RST_BUS_EVENT_IRQ_ENABLE;
    end else if (write_strobe && hit_bus_event_enable) begin
      bus_event_irq_enable_reg <= wbyte[3:0];
    end
  end

  // Endpoint select
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      endpoint_select_reg <= RST_ENDPOINT_SELECT;
    end else if (write_strobe && hit_endpoint_select) begin
      endpoint_select_reg <= wbyte[3:0];
    end
  end

  // Frame number, both halves in one step
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      frame_number_low_reg <= RST_FRAME_NUMBER_LOW;
      frame_number_high_reg <= RST_FRAME_NUMBER_HIGH;
    end else if (USB_EVENT_IN.sof) begin
      frame_number_low_reg <= USB_EVENT_IN.frame_number[7:0];
      frame_number_high_reg <= USB_EVENT_IN.frame_number[10:8];
    end
  end

  // Suspend state, so resume only counts while suspended
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      suspended_reg <= 1'b0;
    end else if (USB_EVENT_IN.bus_reset || USB_EVENT_IN.resume) begin
      suspended_reg <= 1'b0;
    end else if (USB_EVENT_IN.suspend) begin
      suspended_reg <= 1'b1;
    end
  end

  always_comb begin
    bus_event_set = 4'h0;
    bus_event_set[BIT_SOF] = USB_EVENT_IN.sof;
    bus_event_set[BIT_BUS_RESET] = USB_EVENT_IN.bus_reset;
    bus_event_set[BIT_RESUME] = USB_EVENT_IN.resume && suspended_reg;
    bus_event_set[BIT_SUSPEND] = USB_EVENT_IN.suspend;
    out_ep_hi_set = USB_EVENT_IN.out_ep_hi;
  end

  // Bus-event sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      bus_event_irq_flags_reg <= 4'h0;
    end else if (write_strobe && hit_bus_event_flags) begin
      bus_event_irq_flags_reg <= (bus_event_irq_flags_reg & ~wbyte[3:0]) | bus_event_set;
    end else begin
      bus_event_irq_flags_reg <= bus_event_irq_flags_reg | bus_event_set;
    end
  end

  // OUT endpoint 8 to 15 sticky flags, same clear rule
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      out_ep_hi_irq_flags_reg <= 8'h00;
    end else if (write_strobe && hit_out_ep_hi_flags) begin
      out_ep_hi_irq_flags_reg <= (out_ep_hi_irq_flags_reg & ~wbyte) | out_ep_hi_set;
    end else begin
      out_ep_hi_irq_flags_reg <= out_ep_hi_irq_flags_reg | out_ep_hi_set;
    end
  end

  // Enables gate the flags onto the interrupt line
  assign irq_next = |(bus_event_irq_flags_reg & bus_event_irq_enable_reg) ||
    |(out_ep_hi_irq_flags_reg & out_ep_hi_irq_enable_reg);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= irq_next;
    end
  end

  // Status copies, one cycle behind their registers
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ENDPOINT_SELECT_OUT <= RST_ENDPOINT_SELECT;
    end else begin
      ENDPOINT_SELECT_OUT <= endpoint_select_reg;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SUSPENDED_OUT <= 1'b0;
    end else begin
      SUSPENDED_OUT <= suspended_reg;
    end
  end

  // Per-endpoint window storage; even slots IN set, endpoint 0 CSR in slot 1
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        for (int s = 0; s < EP_WINDOW_REGS; s++) begin
          in_csr_mem[e][s] <= 8'h00;
        end
      end
    end else if (wr_window && win_ep_zero_csr) begin
      in_csr_mem[0][EP_ZERO_CSR_SLOT] <= wbyte;
    end else if (wr_window && win_in_slot) begin
      in_csr_mem[endpoint_select_reg][window_slot] <= wbyte;
    end
  end

  // Odd slots of the window hold the selected endpoint's OUT set
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      for (int e = 0; e < EP_COUNT; e++) begin
        for (int s = 0; s < EP_WINDOW_REGS; s++) begin
          out_csr_mem[e][s] <= 8'h00;
        end
      end
    end else if (wr_window && win_out_slot) begin
      out_csr_mem[endpoint_select_reg][window_slot] <= wbyte;
    end
  end

endmodule

// file: design/usb_regs_pkg.sv
// Purpose: Shared constants and types for the USB interrupt enable / frame / index bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Register byte address is four times the register index
package usb_regs_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register indices
  localparam logic [15:0] IDX_OUT_EP_HI_IRQ_ENABLE = 16'hc00a;
  localparam logic [15:0] IDX_BUS_EVENT_IRQ_ENABLE = 16'hc00b;
  localparam logic [15:0] IDX_FRAME_NUMBER_LOW = 16'hc00c;
  localparam logic [15:0] IDX_FRAME_NUMBER_HIGH = 16'hc00d;
  localparam logic [15:0] IDX_ENDPOINT_SELECT = 16'hc00e;
  localparam logic [15:0] IDX_EP_WINDOW_FIRST = 16'hc010;
  localparam logic [15:0] IDX_EP_WINDOW_LAST = 16'hc017;
  localparam logic [15:0] IDX_EP_ZERO_CTRL_STATUS = 16'hc011;
  localparam logic [15:0] IDX_BUS_EVENT_IRQ_FLAGS = 16'hc020;
  localparam logic [15:0] IDX_OUT_EP_HI_IRQ_FLAGS = 16'hc021;

  // Bus-event bit positions
  localparam int BIT_SOF = 3;
  localparam int BIT_BUS_RESET = 2;
  localparam int BIT_RESUME = 1;
  localparam int BIT_SUSPEND = 0;

  // Reset values
  localparam logic [7:0] RST_OUT_EP_HI_IRQ_ENABLE = 8'h00;
  localparam logic [3:0] RST_BUS_EVENT_IRQ_ENABLE = 4'h6;
  localparam logic [7:0] RST_FRAME_NUMBER_LOW = 8'h00;
  localparam logic [2:0] RST_FRAME_NUMBER_HIGH = 3'h0;
  localparam logic [3:0] RST_ENDPOINT_SELECT = 4'h0;
  localparam logic [3:0] BUS_EVENT_UNUSED = 4'h0;

  localparam int EP_COUNT = 16;
  localparam int EP_WINDOW_REGS = 8;
  localparam logic [2:0] EP_ZERO_CSR_SLOT = 3'h1;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic sof;
    logic [10:0] frame_number;
    logic bus_reset;
    logic resume;
    logic suspend;
    logic [7:0] out_ep_hi;
  } usb_event_t;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {{(ADDR_W-18){1'b0}}, idx, 2'b00};
  endfunction

endpackage

// file: tb/usb_regs_checker.sv
// Purpose: Port checks on the register bank
// Assumes: Zero wait APB answer
// Notes: Bound to the top module
`timescale 1ns/1ns
module usb_regs_checker (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Watched ports
  input wire usb_regs_pkg::apb_req_t APB_REQ_IN,
  input wire logic [usb_regs_pkg::DATA_W-1:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire usb_regs_pkg::usb_event_t USB_EVENT_IN,
  input wire logic IRQ_OUT,
  input wire logic [3:0] ENDPOINT_SELECT_OUT,
  input wire logic SUSPENDED_OUT
);
  import usb_regs_pkg::*;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  wire logic setup = APB_REQ_IN.psel && !APB_REQ_IN.penable;
  wire logic rd = PREADY_OUT && !APB_REQ_IN.pwrite;
  wire logic [31:0] addr = APB_REQ_IN.paddr;
  a_ready_setup: assert property (setup |=> PREADY_OUT)
    else $error("No ready after setup");
  a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("Ready longer than one cycle");
  a_err_unaligned: assert property (setup && addr[1:0] != 2'h0 |=> PSLVERR_OUT)
    else $error("Unaligned access not refused");
  a_upper_zero: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("Upper read bits set");
  a_unused_zero: assert property (rd && addr == 32'h3002c |-> PRDATA_OUT[7:4] == 4'h0)
    else $error("Unused enable bits read set");
  a_frame_hi_width: assert property (rd && addr == 32'h30034 |-> PRDATA_OUT[7:3] == 5'h0)
    else $error("Frame high too wide");
  a_select_width: assert property (rd && addr == 32'h30038 |-> PRDATA_OUT[7:4] == 4'h0)
    else $error("Select too wide");
  a_suspend_set: assert property (USB_EVENT_IN.suspend && !USB_EVENT_IN.resume
    && !USB_EVENT_IN.bus_reset |=> ##1 SUSPENDED_OUT) else $error("Suspend not held");
  a_resume_clear: assert property (USB_EVENT_IN.resume || USB_EVENT_IN.bus_reset
    |=> ##1 !SUSPENDED_OUT) else $error("Suspend not left");
  a_select_copy: assert property (PREADY_OUT && APB_REQ_IN.penable && APB_REQ_IN.pwrite
    && APB_REQ_IN.pstrb[0] && addr == 32'h30038 |=> ##1
    ENDPOINT_SELECT_OUT == $past(APB_REQ_IN.pwdata[3:0], 2)) else $error("Select not taken");
  c_irq: cover property ($rose(IRQ_OUT));
  c_err: cover property (PSLVERR_OUT);
  c_sof: cover property (USB_EVENT_IN.sof);
endmodule
bind usb_irq_enable_frame_index_regs usb_regs_checker i_usb_regs_checker (
  .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .APB_REQ_IN(APB_REQ_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .USB_EVENT_IN(USB_EVENT_IN),
  .IRQ_OUT(IRQ_OUT), .ENDPOINT_SELECT_OUT(ENDPOINT_SELECT_OUT), .SUSPENDED_OUT(SUSPENDED_OUT));

// file: tb/usb_host_model.sv
// Purpose: Bus host event source
// Assumes: One pulse per call
// Notes: Frame field scrambled outside sof
`timescale 1ns/1ns
module usb_host_model (
  // Clock
  input wire logic clk_in,
  // Events to the device
  output usb_regs_pkg::usb_event_t event_out
);
  import usb_regs_pkg::*;
  initial event_out = '0;
  task automatic send(input logic [3:0] kind, input logic [10:0] fr, input logic [7:0] ep);
    @(posedge clk_in);
    event_out <= '{kind[3], fr, kind[2], kind[1], kind[0], ep};
    @(posedge clk_in);
    event_out <= '{1'b0, ~fr, 1'b0, 1'b0, 1'b0, 8'h00};
  endtask
endmodule

// file: tb/usb_irq_enable_frame_index_regs_bench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Zero wait APB answer
// Notes: Random values with fixed seed
`timescale 1ns/1ns
module usb_irq_enable_frame_index_regs_bench;
  import usb_regs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  apb_req_t req = '0;
  usb_event_t ev;
  logic [31:0] prdata;
  logic pready, pslverr, irq, susp, e;
  logic [3:0] sel, s;
  logic [31:0] rd;
  logic [10:0] fr;
  logic [7:0] v;
  int err_count = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  usb_irq_enable_frame_index_regs i_usb_irq_enable_frame_index_regs (.CLOCK_IN(clk),
    .RST_IN(rst), .APB_REQ_IN(req), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .USB_EVENT_IN(ev), .IRQ_OUT(irq), .ENDPOINT_SELECT_OUT(sel),
    .SUSPENDED_OUT(susp));
  usb_host_model i_usb_host_model (.clk_in(clk), .event_out(ev));
  function automatic logic [31:0] ba(input logic [15:0] idx);
    return {14'h0, idx, 2'b00};
  endfunction
  function automatic logic [7:0] bus_en_exp(input logic [7:0] d);
    return {4'h0, d[3:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, {24'h0, d}, 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    forever begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    e = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, ba(idx), d);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] x);
    apb(1'b0, ba(idx), 8'h00);
    chk(rd, {24'h0, x});
  endtask
  task automatic wait_irq(input int n, input logic x);
    repeat (n) @(posedge clk);
    chk_bit(irq, x);
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    v = 8'($urandom(32'hb052));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_OUT_EP_HI_IRQ_ENABLE, 8'h00);
    rdc(IDX_BUS_EVENT_IRQ_ENABLE, 8'h06);
    rdc(IDX_FRAME_NUMBER_LOW, 8'h00);
    rdc(IDX_FRAME_NUMBER_HIGH, 8'h00);
    rdc(IDX_ENDPOINT_SELECT, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      fr = 11'($urandom);
      wr(IDX_OUT_EP_HI_IRQ_ENABLE, v);
      rdc(IDX_OUT_EP_HI_IRQ_ENABLE, v);
      wr(IDX_BUS_EVENT_IRQ_ENABLE, v);
      rdc(IDX_BUS_EVENT_IRQ_ENABLE, bus_en_exp(v));
      i_usb_host_model.send(4'h8, fr, 8'h00);
      wr(IDX_FRAME_NUMBER_LOW, ~fr[7:0]);
      rdc(IDX_FRAME_NUMBER_LOW, fr[7:0]);
      rdc(IDX_FRAME_NUMBER_HIGH, {5'h0, fr[10:8]});
    end
    s = 4'($urandom % 15 + 1);
    wr(IDX_ENDPOINT_SELECT, 8'hf0 | s);
    rdc(IDX_ENDPOINT_SELECT, {4'h0, s});
    chk({28'h0, sel}, {28'h0, s});
    wr(IDX_EP_WINDOW_FIRST, 8'ha5);
    wr(IDX_ENDPOINT_SELECT, {4'h0, 4'(s % 15 + 1)});
    wr(IDX_EP_WINDOW_FIRST, 8'h3c);
    rdc(IDX_EP_WINDOW_FIRST, 8'h3c);
    wr(IDX_ENDPOINT_SELECT, {4'h0, s});
    rdc(IDX_EP_WINDOW_FIRST, 8'ha5);
    wr(IDX_ENDPOINT_SELECT, 8'h00);
    wr(IDX_EP_ZERO_CTRL_STATUS, 8'h5a);
    rdc(IDX_EP_ZERO_CTRL_STATUS, 8'h5a);
    rdc(IDX_EP_WINDOW_FIRST, 8'h00);
    wr(IDX_BUS_EVENT_IRQ_FLAGS, 8'hff);
    wr(IDX_OUT_EP_HI_IRQ_FLAGS, 8'hff);
    wr(IDX_OUT_EP_HI_IRQ_ENABLE, 8'h00);
    wr(IDX_BUS_EVENT_IRQ_ENABLE, 8'h08);
    wait_irq(2, 1'b0);
    i_usb_host_model.send(4'h8, 11'h7ff, 8'h00);
    wait_irq(3, 1'b1);
    wr(IDX_BUS_EVENT_IRQ_ENABLE, 8'h00);
    wait_irq(2, 1'b0);
    rdc(IDX_BUS_EVENT_IRQ_FLAGS, 8'h08);
    wr(IDX_BUS_EVENT_IRQ_FLAGS, 8'h08);
    i_usb_host_model.send(4'h2, 11'h000, 8'h00);
    rdc(IDX_BUS_EVENT_IRQ_FLAGS, 8'h00);
    i_usb_host_model.send(4'h1, 11'h000, 8'h00);
    repeat (2) @(posedge clk);
    chk_bit(susp, 1'b1);
    i_usb_host_model.send(4'h2, 11'h000, 8'h00);
    rdc(IDX_BUS_EVENT_IRQ_FLAGS, 8'h03);
    chk_bit(susp, 1'b0);
    v = 8'h01 << ($urandom % 8);
    wr(IDX_OUT_EP_HI_IRQ_ENABLE, v);
    i_usb_host_model.send(4'h0, 11'h000, ~v);
    wait_irq(3, 1'b0);
    i_usb_host_model.send(4'h0, 11'h000, v);
    wait_irq(3, 1'b1);
    wr(IDX_OUT_EP_HI_IRQ_FLAGS, v);
    wait_irq(2, 1'b0);
    apb(1'b0, 32'h0003_0100, 8'h00);
    chk_bit(e, 1'b1);
    apb(1'b0, ba(IDX_ENDPOINT_SELECT) + 32'h1, 8'h00);
    chk_bit(e, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(IDX_BUS_EVENT_IRQ_ENABLE, 8'h06);
    rdc(IDX_FRAME_NUMBER_LOW, 8'h00);
    rdc(IDX_BUS_EVENT_IRQ_FLAGS, 8'h00);
    chk_bit(irq, 1'b0);
    report_and_stop();
  end
endmodule
